// *** design/spf_pkg.sv ***
// Constants, carriers and state codes of the serial page flash command block
package spf_pkg;
  localparam int ROWS = 512;
  localparam int ROW_BYTES = 264;
  localparam int ROW_W = 9;
  localparam int OFF_W = 9;
  localparam int MEM_W = 18;
  localparam int TIME_W = 24;
  localparam logic [OFF_W-1:0] LAST_OFF = 9'h107;
  localparam logic [2:0] GROUP_LAST = 3'h7;
  localparam int CLK_PERIOD_NS = 25;
  localparam int NS_PER_US = 1000;
  // Opcodes
  localparam logic [7:0] OP_ROW_READ = 8'h52;
  localparam logic [7:0] OP_BUF_READ = 8'h54;
  localparam logic [7:0] OP_ROW_TO_BUF = 8'h53;
  localparam logic [7:0] OP_COMPARE = 8'h60;
  localparam logic [7:0] OP_BUF_WRITE = 8'h84;
  localparam logic [7:0] OP_PROG_ERASE = 8'h83;
  localparam logic [7:0] OP_PROG = 8'h88;
  localparam logic [7:0] OP_ROW_CLEAR = 8'h81;
  localparam logic [7:0] OP_GROUP_CLEAR = 8'h50;
  localparam logic [7:0] OP_STATUS = 8'h57;
  // Bits received before each phase, counted from the chip-select fall
  localparam logic [6:0] CNT_OPCODE_DONE = 7'h07;
  localparam logic [6:0] CNT_ADDR_DONE = 7'h1F;
  localparam logic [6:0] START_STATUS = 7'h08;
  localparam logic [6:0] START_BUF_WR = 7'h20;
  localparam logic [6:0] START_BUF_RD = 7'h28;
  localparam logic [6:0] START_ROW_RD = 7'h40;
  localparam logic [6:0] CNT_SAT = 7'h40;
  // Address field layout
  localparam int ADDR_W = 24;
  localparam int ROW_MSB = 17;
  localparam int ROW_LSB = 9;
  localparam int GROUP_LSB = 12;
  localparam int OFF_MSB = 8;
  // Status byte fields and erased byte value
  localparam logic [2:0] DENSITY_CODE = 3'h1;
  localparam logic [2:0] STATUS_LOW = 3'h0;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;

  typedef struct packed {
    logic fromBuf;
    logic [ROW_W-1:0] row;
    logic [OFF_W-1:0] off;
  } spf_rd_req_s;

  typedef struct packed {
    logic [OFF_W-1:0] off;
    logic [7:0] data;
  } spf_wr_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_MOVE = 6'h02,
    ST_CMP = 6'h04,
    ST_CLR = 6'h08,
    ST_PROG = 6'h10,
    ST_WAIT = 6'h20
  } spf_state_e;
endpackage

// *** design/spf_flash_cmd.sv ***
// Serial page flash: link decoder on the serial clock, array sequencer on sys_clk
module spf_flash_cmd
  import spf_pkg::*;
#(
  parameter int ROW_MOVE_TIME_US = 200,
  parameter int ERASE_WRITE_TIME_US = 20000,
  parameter int WRITE_TIME_US = 14000,
  parameter int ROW_CLEAR_TIME_US = 8000,
  parameter int GROUP_CLEAR_TIME_US = 10000
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic csn,
  input wire logic si,
  output logic soOut,
  output logic soOe,
  output logic readyOut,
  output logic readyOe
);
  import spf_pkg::*;

  localparam int ROW_MOVE_CYC = ROW_MOVE_TIME_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int ERASE_WRITE_CYC = ERASE_WRITE_TIME_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int WRITE_CYC = WRITE_TIME_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int ROW_CLEAR_CYC = ROW_CLEAR_TIME_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int GROUP_CLEAR_CYC = GROUP_CLEAR_TIME_US * NS_PER_US / CLK_PERIOD_NS;

  function automatic logic [OFF_W-1:0] offInc(input logic [OFF_W-1:0] off);
    offInc = (off >= LAST_OFF) ? '0 : off + 9'h001;
  endfunction

  function automatic logic [MEM_W-1:0] memIdx(input logic [ROW_W-1:0] row,
                                              input logic [OFF_W-1:0] off);
    memIdx = MEM_W'(row * ROW_BYTES + off);
  endfunction

  // ---------------- Link side, serial clock domain ----------------
  logic linkRstN;
  logic [6:0] bitCnt_r;
  logic [2:0] bitPos_r;
  logic [7:0] inSh_r;
  logic [ADDR_W-1:0] addrSh_r;
  logic [7:0] opcode_r;
  logic [ADDR_W-1:0] addr_r;
  logic cmdDone_r;
  logic [OFF_W-1:0] off_r;
  logic rdTgl_r;
  logic wrTgl_r;
  spf_rd_req_s rdReq_r;
  spf_wr_s wrPkt_r;
  logic [7:0] outSh_r;
  logic soOe_r;
  logic [7:0] inNxt;
  logic [ADDR_W-1:0] addrNxt;
  logic isRowRd;
  logic isBufRd;
  logic isBufWr;
  logic isStat;
  logic [6:0] dataStart;
  logic inData;
  logic [7:0] rdData_r;
  logic [7:0] statusByte_r;
  logic [1:0] flagMeta_r;
  logic [1:0] flagSync_r;

  // Bit counters, shift registers and the output shifter are held in reset while chip select is high
  assign linkRstN = rstn & ~csn;
  assign inNxt = {inSh_r[6:0], si};
  assign addrNxt = {addrSh_r[ADDR_W-2:0], si};

  always_comb
  begin
    isRowRd = opcode_r == OP_ROW_READ;
    isBufRd = opcode_r == OP_BUF_READ;
    isBufWr = opcode_r == OP_BUF_WRITE;
    isStat = opcode_r == OP_STATUS;
    dataStart = isRowRd ? START_ROW_RD : isBufRd ? START_BUF_RD :
                isBufWr ? START_BUF_WR : START_STATUS;
    inData = bitCnt_r >= dataStart;
  end

  always_ff @(posedge sck or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      bitCnt_r <= '0;
      bitPos_r <= '0;
      inSh_r <= '0;
      addrSh_r <= '0;
    end
    else
    begin
      inSh_r <= inNxt;
      addrSh_r <= addrNxt;
      bitPos_r <= bitPos_r + 3'h1;
      // Saturates so data phases run as long as the host clocks
      if (bitCnt_r != CNT_SAT)
        bitCnt_r <= bitCnt_r + 7'h01;
    end
  end

  // Command and transfer state survives the chip-select rise for the sequencer
  always_ff @(posedge sck or negedge rstn)
  begin
    if (!rstn)
    begin
      opcode_r <= '0;
      addr_r <= '0;
      cmdDone_r <= 1'b0;
      off_r <= '0;
      rdTgl_r <= 1'b0;
      wrTgl_r <= 1'b0;
      rdReq_r <= '0;
      wrPkt_r <= '0;
    end
    else
    begin
      if (bitCnt_r == '0)
        cmdDone_r <= 1'b0;
      if (bitCnt_r == CNT_OPCODE_DONE)
        opcode_r <= inNxt;
      if (bitCnt_r == CNT_ADDR_DONE)
      begin
        addr_r <= addrNxt;
        cmdDone_r <= 1'b1;
      end
      if (bitCnt_r == CNT_ADDR_DONE && (isRowRd || isBufRd))
      begin
        rdTgl_r <= ~rdTgl_r;
        rdReq_r <= '{fromBuf: isBufRd, row: addrNxt[ROW_MSB:ROW_LSB],
                     off: addrNxt[OFF_MSB:0]};
        off_r <= offInc(addrNxt[OFF_MSB:0]);
      end
      else if (bitCnt_r == CNT_ADDR_DONE)
        off_r <= addrNxt[OFF_MSB:0];
      else if (inData && bitPos_r == '0 && (isRowRd || isBufRd))
      begin
        rdTgl_r <= ~rdTgl_r;
        rdReq_r.off <= off_r;
        off_r <= offInc(off_r);
      end
      else if (inData && bitPos_r == 3'h7 && isBufWr)
      begin
        wrTgl_r <= ~wrTgl_r;
        wrPkt_r <= '{off: off_r, data: inNxt};
        off_r <= offInc(off_r);
      end
    end
  end

  // Ready and compare flags are independent bits, so each gets a plain two-flop sync
  // Limitation: status seen on the link lags two serial clocks
  always_ff @(posedge sck or negedge rstn)
  begin
    if (!rstn)
    begin
      flagMeta_r <= '0;
      flagSync_r <= '0;
    end
    else
    begin
      flagMeta_r <= statusByte_r[7:6];
      flagSync_r <= flagMeta_r;
    end
  end

  always_ff @(negedge sck or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      outSh_r <= '0;
      soOe_r <= 1'b0;
    end
    else if (inData && bitPos_r == '0 && (isRowRd || isBufRd || isStat))
    begin
      outSh_r <= isStat ? {flagSync_r, DENSITY_CODE, STATUS_LOW} : rdData_r;
      soOe_r <= 1'b1;
    end
    else
      outSh_r <= {outSh_r[6:0], 1'b0};
  end

  assign soOut = outSh_r[7];
  assign soOe = soOe_r;

  // ---------------- Array side, system clock domain ----------------
  logic [1:0] csSync_r;
  logic csPrev_r;
  logic [1:0] rdSync_r;
  logic rdPrev_r;
  logic [1:0] wrSync_r;
  logic wrPrev_r;
  logic csRise;
  logic rdEvt;
  logic wrEvt;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      csSync_r <= 2'h3;
      csPrev_r <= 1'b1;
      rdSync_r <= '0;
      rdPrev_r <= 1'b0;
      wrSync_r <= '0;
      wrPrev_r <= 1'b0;
    end
    else
    begin
      csSync_r <= {csSync_r[0], csn};
      csPrev_r <= csSync_r[1];
      rdSync_r <= {rdSync_r[0], rdTgl_r};
      rdPrev_r <= rdSync_r[1];
      wrSync_r <= {wrSync_r[0], wrTgl_r};
      wrPrev_r <= wrSync_r[1];
    end
  end

  assign csRise = csSync_r[1] & ~csPrev_r;
  assign rdEvt = rdSync_r[1] ^ rdPrev_r;
  assign wrEvt = wrSync_r[1] ^ wrPrev_r;

  spf_state_e state_r;
  spf_state_e goState;
  logic [TIME_W-1:0] goTarget;
  logic [TIME_W-1:0] timer_r;
  logic [TIME_W-1:0] target_r;
  logic [OFF_W-1:0] idx_r;
  logic [ROW_W-1:0] row_r;
  logic [ROW_W-1:0] lastRow_r;
  logic [7:0] op_r;
  logic missAcc_r;
  logic cmpMiss_r;
  logic launch;
  logic lastByte;
  logic mismatch;
  logic missNow;
  logic isGroup;
  logic [MEM_W-1:0] sweepIdx;
  logic [7:0] memArr [0:ROWS*ROW_BYTES-1];
  logic [7:0] bufArr [0:ROW_BYTES-1];

  always_comb
  begin
    goState = ST_IDLE;
    goTarget = '0;
    case (opcode_r)
      OP_ROW_TO_BUF:
      begin
        goState = ST_MOVE;
        goTarget = TIME_W'(ROW_MOVE_CYC);
      end
      OP_COMPARE:
      begin
        goState = ST_CMP;
        goTarget = TIME_W'(ROW_MOVE_CYC);
      end
      OP_PROG_ERASE:
      begin
        goState = ST_CLR;
        goTarget = TIME_W'(ERASE_WRITE_CYC);
      end
      OP_PROG:
      begin
        goState = ST_PROG;
        goTarget = TIME_W'(WRITE_CYC);
      end
      OP_ROW_CLEAR:
      begin
        goState = ST_CLR;
        goTarget = TIME_W'(ROW_CLEAR_CYC);
      end
      OP_GROUP_CLEAR:
      begin
        goState = ST_CLR;
        goTarget = TIME_W'(GROUP_CLEAR_CYC);
      end
      default:
        goState = ST_IDLE;
    endcase
  end

  assign launch = csRise && cmdDone_r && state_r == ST_IDLE && goState != ST_IDLE;
  assign isGroup = opcode_r == OP_GROUP_CLEAR;
  assign lastByte = idx_r == LAST_OFF;
  assign sweepIdx = memIdx(row_r, idx_r);
  assign mismatch = memArr[sweepIdx] != bufArr[idx_r];
  assign missNow = missAcc_r | mismatch;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      timer_r <= '0;
      target_r <= '0;
      idx_r <= '0;
      row_r <= '0;
      lastRow_r <= '0;
      op_r <= '0;
      missAcc_r <= 1'b0;
      cmpMiss_r <= 1'b0;
    end
    else
    begin
      timer_r <= timer_r + 1'b1;
      case (state_r)
        ST_IDLE:
          if (launch)
          begin
            state_r <= goState;
            target_r <= goTarget;
            timer_r <= '0;
            idx_r <= '0;
            op_r <= opcode_r;
            missAcc_r <= 1'b0;
            row_r <= isGroup ? {addr_r[ROW_MSB:GROUP_LSB], 3'h0} : addr_r[ROW_MSB:ROW_LSB];
            lastRow_r <= isGroup ? {addr_r[ROW_MSB:GROUP_LSB], GROUP_LAST}
                                 : addr_r[ROW_MSB:ROW_LSB];
          end
        ST_MOVE, ST_CMP, ST_PROG:
        begin
          idx_r <= offInc(idx_r);
          if (state_r == ST_CMP)
            missAcc_r <= missAcc_r | mismatch;
          if (state_r == ST_CMP && lastByte)
            cmpMiss_r <= missAcc_r | mismatch;
          if (lastByte)
            state_r <= ST_WAIT;
        end
        ST_CLR:
        begin
          idx_r <= offInc(idx_r);
          if (lastByte && row_r != lastRow_r)
            row_r <= row_r + 9'h001;
          else if (lastByte)
            state_r <= (op_r == OP_PROG_ERASE) ? ST_PROG : ST_WAIT;
        end
        ST_WAIT:
          if (timer_r >= target_r)
            state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (state_r == ST_CLR)
      memArr[sweepIdx] <= BYTE_ERASED;
    else if (state_r == ST_PROG)
      memArr[sweepIdx] <= (op_r == OP_PROG_ERASE) ? bufArr[idx_r]
                                                  : memArr[sweepIdx] & bufArr[idx_r];
  end

  always_ff @(posedge sys_clk)
  begin
    if (state_r == ST_MOVE)
      bufArr[idx_r] <= memArr[sweepIdx];
    else if (wrEvt && state_r == ST_IDLE)
      bufArr[wrPkt_r.off] <= wrPkt_r.data;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdData_r <= '0;
      statusByte_r <= '0;
      readyOe <= 1'b0;
      readyOut <= 1'b0;
    end
    else
    begin
      if (rdEvt)
        rdData_r <= rdReq_r.fromBuf ? bufArr[rdReq_r.off]
                                    : memArr[memIdx(rdReq_r.row, rdReq_r.off)];
      statusByte_r <= {state_r == ST_IDLE, cmpMiss_r, DENSITY_CODE, STATUS_LOW};
      readyOe <= state_r != ST_IDLE;
      readyOut <= 1'b0;
    end
  end

  a_launch_copy: assert property (@(posedge sys_clk) disable iff (!rstn)
    launch && opcode_r == OP_ROW_TO_BUF |=> state_r == ST_MOVE)
    else $error("copy did not start on chip-select rise");
  a_busy_status: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_r != ST_IDLE |=> !statusByte_r[7])
    else $error("ready bit high while busy");
  a_cmp_result: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_r == ST_CMP && lastByte |=> cmpMiss_r == $past(missNow))
    else $error("compare result not stored");
  a_cmp_busy: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_r == ST_CMP |=> state_r == ST_CMP || state_r == ST_WAIT)
    else $error("compare left busy early");
  a_clear_ones: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_r == ST_CLR |=> memArr[$past(sweepIdx)] == BYTE_ERASED)
    else $error("erased byte not all ones");
  a_group_rows: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_r == ST_CLR && op_r == OP_GROUP_CLEAR |-> row_r[8:3] == lastRow_r[8:3])
    else $error("group erase left its group");
  a_wait_end: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_r == ST_WAIT && timer_r >= target_r |=> state_r == ST_IDLE ##1 readyOe == 1'b0)
    else $error("busy outlasted its time");
  a_row_read_quiet: assert property (@(posedge sck) disable iff (!linkRstN)
    isRowRd && bitCnt_r < START_ROW_RD |-> !soOe_r)
    else $error("row read drove output before filler end");
  a_unknown_quiet: assert property (@(posedge sck) disable iff (!linkRstN)
    bitCnt_r > CNT_OPCODE_DONE && !(isRowRd || isBufRd || isStat) |-> !soOe_r)
    else $error("output driven for unknown opcode");
  a_offset_range: assert property (@(posedge sck) disable iff (!linkRstN)
    inData && bitPos_r == '0 && (isRowRd || isBufRd) && off_r == LAST_OFF |=> off_r == '0)
    else $error("offset failed to wrap");

  c_copy_done: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_r == ST_MOVE && lastByte);
  c_cmp_miss: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_r == ST_CMP && lastByte && mismatch);
  c_group_clear: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_r == ST_CLR && op_r == OP_GROUP_CLEAR && row_r == lastRow_r);
  c_status_stream: cover property (@(posedge sck) disable iff (!linkRstN)
    isStat && bitCnt_r > START_STATUS && bitPos_r == '0);
endmodule

// *** dv/spf_host.sv ***
// Host-side serial master model for the page flash link
module spf_host (
  output logic sck,
  output logic csn,
  output logic si,
  input wire logic so
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sck = 1'b0;
    csn = 1'b1;
    si = 1'b0;
  end

  // mode 0 idles low, mode 3 idles high, msb first
  task automatic frame(input logic [7:0] tx[$], input int nb, output logic [7:0] rx[$],
    input logic idleHigh);
    logic [7:0] b;
    logic [7:0] r;
    rx = {};
    // Mode change only while deselected, well before the select falls
    if (sck !== idleHigh)
    begin
      sck = idleHigh;
      #32;
    end
    csn = 1'b0;
    #32;
    for (int i = 0; i < nb; i++)
    begin
      b = (i < tx.size()) ? tx[i] : 8'h00;
      for (int k = 7; k >= 0; k--)
      begin
        sck = 1'b0;
        si = b[k];
        #32;
        sck = 1'b1;
        r[k] = so;
        #32;
      end
      rx.push_back(r);
    end
    sck = idleHigh;
    #16;
    csn = 1'b1;
    // Idle data line flips once at deselect so a stale bit is never mistaken for data
    si = ~si;
    #200;
  endtask
endmodule

// *** dv/test_serial_page_flash_commands.sv ***
// Self-checking bench for the serial page flash command block
module test_serial_page_flash_commands;
  timeunit 1ns;
  timeprecision 1ps;
  import spf_pkg::*;

  typedef logic [7:0] spf_bq_t[$];

  logic sys_clk;
  logic rstn;
  logic sck;
  logic csn;
  logic si;
  logic soOut;
  logic soOe;
  logic readyOut;
  logic readyOe;
  logic soLast;
  logic droveSo;
  logic modeThree;
  wire soWire;
  wire readyWire;
  int numErrors;
  int nCompared;
  int cycles;
  logic [7:0] bufExp [ROW_BYTES];
  logic [7:0] rowFive [ROW_BYTES];

  // Released output shows the inverse of its last bit
  always @*
  begin
    if (soOe === 1'b1)
      soLast = soOut;
  end
  assign soWire = (soOe === 1'b1) ? soOut : ~soLast;
  assign readyWire = (readyOe === 1'b1) ? readyOut : 1'b1;

  spf_flash_cmd #(
    .ROW_MOVE_TIME_US(10),
    .ERASE_WRITE_TIME_US(100),
    .WRITE_TIME_US(50),
    .ROW_CLEAR_TIME_US(50),
    .GROUP_CLEAR_TIME_US(80)
  ) dut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .sck(sck),
    .csn(csn),
    .si(si),
    .soOut(soOut),
    .soOe(soOe),
    .readyOut(readyOut),
    .readyOe(readyOe)
  );

  spf_host host (
    .sck(sck),
    .csn(csn),
    .si(si),
    .so(soWire)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  always @(posedge sck)
  begin
    if (soOe === 1'b1)
      droveSo = 1'b1;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      $display("[ERR] %0t run exceeded its cycle ceiling", $time);
      numErrors++;
      stopTest();
    end
  end

  task automatic stopTest();
    if (numErrors == 0 && nCompared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    nCompared++;
    if (got !== exp)
    begin
      $display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
      numErrors++;
    end
  endtask

  function automatic logic [7:0] stat(input logic miss);
    return {1'b1, miss, DENSITY_CODE, STATUS_LOW};
  endfunction

  function automatic spf_bq_t hdr(input logic [7:0] op, input logic [23:0] a);
    spf_bq_t q;
    q = {op, a[23:16], a[15:8], a[7:0]};
    return q;
  endfunction

  // Reserved top bits set so that ignoring them is exercised
  function automatic logic [23:0] rowAddr(input logic [8:0] row, input logic [8:0] off);
    return {6'h3F, row, off};
  endfunction

  task automatic xfer(input spf_bq_t tx, input int nb, output spf_bq_t rx);
    @(posedge sys_clk);
    #1;
    droveSo = 1'b0;
    host.frame(tx, nb, rx, modeThree);
  endtask

  task automatic wrBuf(input logic [8:0] off, input spf_bq_t d);
    spf_bq_t tx;
    spf_bq_t rx;
    int o;
    tx = hdr(OP_BUF_WRITE, {15'h7FFF, off});
    o = off;
    foreach (d[i])
    begin
      tx.push_back(d[i]);
      bufExp[o] = d[i];
      o = (o + 1) % ROW_BYTES;
    end
    xfer(tx, tx.size(), rx);
  endtask

  task automatic rdCheck(input logic [7:0] op, input logic [23:0] a, input int nf,
    input spf_bq_t exp, input string what);
    spf_bq_t rx;
    xfer(hdr(op, a), 4 + nf + exp.size(), rx);
    foreach (exp[i])
      check(rx[4 + nf + i], exp[i], what);
    check({7'h0, soOe}, 8'h00, "output not released after frame");
  endtask

  task automatic launch(input logic [7:0] op, input logic [23:0] a, input logic miss);
    spf_bq_t rx;
    int n;
    xfer(hdr(op, a), 4, rx);
    n = 0;
    while (readyWire !== 1'b0 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check({7'h0, readyWire}, 8'h00, "ready pin not low while busy");
    xfer('{OP_STATUS}, 2, rx);
    check(rx[1] & 8'h80, 8'h00, "status not busy during operation");
    n = 0;
    while (readyWire !== 1'b1 && n < 6000)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    xfer('{OP_STATUS}, 3, rx);
    check(rx[1], stat(miss), "status after operation");
    check(rx[2], stat(miss), "status repeat");
  endtask

  task automatic testReset();
    spf_bq_t rx;
    check({6'h0, soOe, readyOe}, 8'h00, "outputs after reset");
    xfer('{OP_STATUS}, 3, rx);
    check(rx[1], stat(1'b0), "status after reset");
    check(rx[2], stat(1'b0), "status second byte");
  endtask

  task automatic testBuffer();
    spf_bq_t d;
    for (int i = 0; i < ROW_BYTES; i++)
      d.push_back(8'(i) ^ 8'h5A);
    wrBuf(9'h000, d);
    wrBuf(9'h106, '{8'hA1, 8'hA2, 8'hB1, 8'hB2});
    rdCheck(OP_BUF_READ, {15'h7FFF, 9'h106}, 1,
      '{8'hA1, 8'hA2, 8'hB1, 8'hB2, bufExp[2]}, "buffer wrap read");
  endtask

  task automatic testProgram();
    launch(OP_PROG_ERASE, rowAddr(9'h005, 9'h0AA), 1'b0);
    rowFive = bufExp;
    wrBuf(9'h000, '{8'h33});
    rdCheck(OP_ROW_READ, rowAddr(9'h005, 9'h105), 4,
      '{rowFive[261], rowFive[262], rowFive[263], rowFive[0]}, "row read wrap");
    rdCheck(OP_BUF_READ, {15'h7FFF, 9'h000}, 1, '{8'h33}, "buffer altered by row read");
  endtask

  task automatic testCompare();
    launch(OP_COMPARE, rowAddr(9'h005, 9'h1FF), 1'b1);
    wrBuf(9'h000, '{rowFive[0]});
    launch(OP_COMPARE, rowAddr(9'h005, 9'h1FF), 1'b0);
  endtask

  task automatic testClearProgram();
    launch(OP_ROW_CLEAR, rowAddr(9'h006, 9'h000), 1'b0);
    rdCheck(OP_ROW_READ, rowAddr(9'h006, 9'h000), 4,
      '{BYTE_ERASED, BYTE_ERASED}, "row not cleared");
    launch(OP_PROG, rowAddr(9'h006, 9'h000), 1'b0);
    rdCheck(OP_ROW_READ, rowAddr(9'h006, 9'h010), 4,
      '{bufExp[16], bufExp[17]}, "row not programmed");
  endtask

  task automatic testCopy();
    wrBuf(9'h020, '{8'h00, 8'h00});
    launch(OP_ROW_TO_BUF, rowAddr(9'h005, 9'h000), 1'b0);
    bufExp = rowFive;
    rdCheck(OP_BUF_READ, {15'h7FFF, 9'h020}, 1,
      '{rowFive[32], rowFive[33]}, "row not copied");
  endtask

  task automatic testGroup();
    launch(OP_GROUP_CLEAR, {6'h3F, 6'h00, 12'hFFF}, 1'b0);
    rdCheck(OP_ROW_READ, rowAddr(9'h005, 9'h000), 4,
      '{BYTE_ERASED, BYTE_ERASED}, "group row 5 not cleared");
    rdCheck(OP_ROW_READ, rowAddr(9'h007, 9'h107), 4,
      '{BYTE_ERASED, BYTE_ERASED}, "group row 7 not cleared");
  endtask

  task automatic testUnknown();
    spf_bq_t rx;
    xfer('{8'hA5, 8'hFF, 8'hFF, 8'hFF}, 10, rx);
    check({7'h0, droveSo}, 8'h00, "unknown opcode drove output");
  endtask

  // Clock idles high; buffer holds row 5 since the copy
  task automatic testModeThree();
    spf_bq_t rx;
    modeThree = 1'b1;
    rdCheck(OP_BUF_READ, {15'h7FFF, 9'h020}, 1,
      '{rowFive[32], rowFive[33]}, "mode 3 buffer read");
    xfer('{OP_STATUS}, 3, rx);
    check(rx[1], stat(1'b0), "mode 3 status");
    check(rx[2], stat(1'b0), "mode 3 status repeat");
  endtask

  initial
  begin
    rstn = 1'b0;
    soLast = 1'b0;
    droveSo = 1'b0;
    numErrors = 0;
    nCompared = 0;
    cycles = 0;
    modeThree = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    testReset();
    testBuffer();
    testProgram();
    testCompare();
    testClearProgram();
    testCopy();
    testGroup();
    testUnknown();
    testModeThree();
    stopTest();
  end
endmodule
